// >>> shared/jitc_pkg.sv
// constants, types and register map of the in-frame response transmit control
// assumes a symbol engine that times each symbol on the bus and reports back
package jitc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int unsigned JITC_AW = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_DATA = 4'h4;
  localparam logic [3:0] OFF_SV   = 4'h8;

  // control register fields
  localparam int unsigned BIT_FAST   = 6;
  localparam int unsigned BIT_NORM_BIT_FORMAT_SEL   = 5;
  localparam int unsigned BIT_EOD    = 3;
  localparam int unsigned BIT_SINGLE = 2;
  localparam int unsigned BIT_MCRC   = 1;
  localparam int unsigned BIT_MNOCRC = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // state vector codes
  localparam logic [7:0] SV_NONE    = 8'h00;
  localparam logic [7:0] SV_TRANSMIT_DATA_EMPTY    = 8'h10;
  localparam logic [7:0] SV_INVALID = 8'h1c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // symbol commands and sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_NB   = 3'h1,
    OP_BYTE = 3'h2,
    OP_CRC  = 3'h3,
    OP_EOD  = 3'h4,
    OP_ONES = 3'h5
  } jitc_op_t;

  typedef struct packed {
    jitc_op_t   op;
    logic [7:0] data;
  } jitc_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_NB    = 3'h1,
    S_BYTE  = 3'h2,
    S_CRC   = 3'h3,
    S_EOD   = 3'h4,
    S_ONES  = 3'h5,
    S_RETRY = 3'h6
  } jitc_state_t;

endpackage

// >>> hw/jitc_transmit_control.sv
// transmit control: control, data and state vector registers on axi4-lite,
// plus the sequencer for messages and in-frame responses
// assumes a symbol engine that takes one command per valid/ready handshake,
// pulses sym_done_in when it went out intact and reports bus events as pulses
//
// Function
// R1: fast bit: receive only at 41.6 Kbps
// R2: break clears fast bit, vector shows 0x1c
// R3: normalization bit polarity from format select
// R4: crc follows current byte on end request
// R5: queued shadow byte goes before the crc
// R6: end request clears transmit-data-empty at once
// R7: end request cleared at crc start or error; for in-frame responses the code clears it on the received end symbol instead
// R8: response requests priority encoded, read as written
// R9: software sets one response request only
// R10: active normalization bit precedes response byte
// R11: single response sent after valid end symbol
// R12: single request cleared on success, end, error
// R13: single request ignored once end symbol seen
// R14: lost single response retried without normalization bit
// R15: no extra ones for single response loss
// R16: multi response raises empty on each load
// R17: no-crc multi response ends without crc
// R18: multi request cleared on end, error, underrun
// R19: multi request ignored once end symbol seen
// R20: multi loss clears request, last bit adds ones
// R21: software feeds bytes then sets end request
// R22: crc multi response appends crc before end
`timescale 1ns/10ps
module jitc_transmit_control
  import jitc_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [jitc_pkg::JITC_AW-1:0] s_axi_awaddr_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  output logic [1:0]                    s_axi_bresp_out,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  input  wire logic [jitc_pkg::JITC_AW-1:0] s_axi_araddr_in,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  output logic [31:0]                   s_axi_rdata_out,
  output logic [1:0]                    s_axi_rresp_out,
  output logic                          cmd_valid_out,
  input  wire logic                     cmd_ready_in,
  output jitc_pkg::jitc_cmd_t           cmd_out,
  input  wire logic                     sym_done_in,
  input  wire logic                     arb_lost_in,
  input  wire logic                     arb_last_bit_in,
  input  wire logic                     win_byte_done_in,
  input  wire logic                     crc_first_bit_in,
  input  wire logic                     eod_rx_in,
  input  wire logic                     eof_rx_in,
  input  wire logic                     break_rx_in,
  input  wire logic                     bus_error_in,
  output logic                          fast_receive_enable_out,
  output logic                          norm_bit_expect_out
);
  import jitc_pkg::*;

  // ----------------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------------
  logic                 aw_have_q, w_have_q;
  logic [JITC_AW-1:0]   awaddr_q;
  logic [7:0]           wdata_q;
  logic                 wstrb0_q;
  logic                 wr_go, rd_go;
  logic                 wr_ctrl, wr_data, rd_sv;

  assign s_axi_awready_out = !aw_have_q && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_have_q && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign wr_go   = aw_have_q && w_have_q && !s_axi_bvalid_out;
  assign rd_go   = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_ctrl = wr_go && wstrb0_q && (awaddr_q == OFF_CTRL);
  assign wr_data = wr_go && wstrb0_q && (awaddr_q == OFF_DATA);
  assign rd_sv   = rd_go && (s_axi_araddr_in == OFF_SV);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in[7:0];
        wstrb0_q <= s_axi_wstrb_in[0];
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (awaddr_q == OFF_CTRL || awaddr_q == OFF_DATA ||
                           awaddr_q == OFF_SV) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic        fast_q, norm_bit_format_sel_q, eod_q, eod_seen_q, transmit_data_empty_q, invalid_q;
  logic        shadow_full_q, ifr_q, issued_q;
  logic [2:0]  req_q;
  logic [2:0]  eff;
  logic [7:0]  shadow_q, shift_q, ctrl_rd, sv_rd;
  logic [2:0]  clr_req;
  logic        clr_eod, move, done, eod_set;
  jitc_state_t state_q, state_d;

  // single beats crc-multi beats nocrc-multi
  assign eff = req_q[2] ? 3'b100 : req_q[1] ? 3'b010 : {2'b00, req_q[0]}; // R8
  assign done    = sym_done_in && issued_q;
  assign eod_set = wr_ctrl && wdata_q[BIT_EOD] && !eod_q;
  assign ctrl_rd = {1'b0, fast_q, norm_bit_format_sel_q, 1'b0, eod_q, req_q}; // R8
  assign sv_rd   = invalid_q ? SV_INVALID : transmit_data_empty_q ? SV_TRANSMIT_DATA_EMPTY : SV_NONE;
  assign fast_receive_enable_out = fast_q; // R1
  assign norm_bit_expect_out     = eff[1] ^ norm_bit_format_sel_q; // R3

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= RESP_OKAY;
      case (s_axi_araddr_in)
        OFF_CTRL: s_axi_rdata_out <= {24'h000000, ctrl_rd};
        OFF_DATA: s_axi_rdata_out <= {24'h000000, shadow_q};
        OFF_SV:   s_axi_rdata_out <= {24'h000000, sv_rd};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fast_q <= CTRL_RESET[BIT_FAST];
      norm_bit_format_sel_q <= CTRL_RESET[BIT_NORM_BIT_FORMAT_SEL];
    end else begin
      if (wr_ctrl) begin
        norm_bit_format_sel_q <= wdata_q[BIT_NORM_BIT_FORMAT_SEL];
      end
      if (break_rx_in) begin
        fast_q <= 1'b0; // R2
      end else if (wr_ctrl) begin
        fast_q <= wdata_q[BIT_FAST]; // R1
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_q      <= CTRL_RESET[2:0];
      eod_q      <= CTRL_RESET[BIT_EOD];
      eod_seen_q <= 1'b0;
    end else begin
      // request writes after a received end symbol can clear bits but not set them
      if (wr_ctrl && !eod_seen_q && !eod_rx_in) begin
        req_q <= wdata_q[2:0] & ~clr_req; // R13 R19
      end else if (wr_ctrl) begin
        req_q <= req_q & wdata_q[2:0] & ~clr_req; // R13 R19
      end else begin
        req_q <= req_q & ~clr_req;
      end
      if (clr_eod) begin
        eod_q <= 1'b0; // R7
      end else if (wr_ctrl) begin
        eod_q <= wdata_q[BIT_EOD];
      end
      if (eod_rx_in) begin
        eod_seen_q <= 1'b1;
      end else if (eof_rx_in) begin
        eod_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_q      <= DATA_RESET;
      shadow_full_q <= 1'b0;
      shift_q       <= DATA_RESET;
      transmit_data_empty_q        <= 1'b0;
      invalid_q     <= 1'b0;
    end else begin
      if (wr_data) begin
        shadow_q <= wdata_q;
      end
      shadow_full_q <= wr_data || (shadow_full_q && !move);
      if (move) begin
        shift_q <= shadow_q; // R5
      end
      // a load for a multi or main byte raises empty; set wins over clear
      if (move && !eff[2]) begin
        transmit_data_empty_q <= 1'b1; // R16
      end else if (wr_data || eod_set) begin
        transmit_data_empty_q <= 1'b0; // R6
      end
      if (break_rx_in) begin
        invalid_q <= 1'b1; // R2
      end else if (rd_sv) begin
        invalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    move    = 1'b0;
    clr_req = 3'b000;
    clr_eod = 1'b0;
    if (eod_set) begin
      clr_req[2] = 1'b1; // R12
    end
    if (ifr_q && eod_rx_in) begin
      clr_eod = 1'b1; // R7
    end
    if (!ifr_q && crc_first_bit_in) begin
      clr_eod = 1'b1; // R7
    end
    if (bus_error_in) begin
      state_d = S_IDLE;
      clr_req = 3'b111; // R12 R18
      clr_eod = 1'b1; // R7
    end else begin
      case (state_q)
        S_IDLE: begin
          if (eff != 3'b000 && eod_rx_in && !fast_q) begin
            state_d = S_NB; // R10 R11
          end else if (eff == 3'b000 && shadow_full_q && !fast_q) begin
            state_d = S_BYTE;
            move    = 1'b1;
          end
        end
        S_NB: begin
          if (done) begin
            state_d = S_BYTE; // R10 R16
            move    = 1'b1;
          end
        end
        S_BYTE: begin
          if (arb_lost_in) begin
            if (ifr_q && eff[2]) begin
              state_d = S_RETRY; // R14 R15
            end else if (ifr_q) begin
              clr_req = 3'b011; // R20
              state_d = arb_last_bit_in ? S_ONES : S_IDLE; // R20
            end else begin
              clr_eod = 1'b1;
              state_d = S_IDLE;
            end
          end else if (done) begin
            if (eff[2]) begin
              clr_req[2] = 1'b1; // R12
              state_d    = S_IDLE;
            end else if (shadow_full_q) begin
              state_d = S_BYTE; // R5 R16
              move    = 1'b1;
            end else if (eod_q) begin
              state_d = (ifr_q && eff[0]) ? S_EOD : S_CRC; // R4 R17 R22
            end else begin
              clr_req = 3'b011; // R18
              clr_eod = 1'b1;
              state_d = S_IDLE;
            end
          end
        end
        S_RETRY: begin
          if (!eff[2]) begin
            state_d = S_IDLE; // R14
          end else if (win_byte_done_in) begin
            state_d = S_BYTE; // R14
          end
        end
        S_CRC: begin
          if (done) begin
            state_d = S_EOD; // R4 R22
          end
        end
        S_EOD: begin
          if (done) begin
            clr_req = 3'b011; // R18
            state_d = S_IDLE;
          end
        end
        S_ONES: begin
          if (done) begin
            state_d = S_IDLE;
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  assign cmd_valid_out = !issued_q && state_q != S_IDLE && state_q != S_RETRY;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q  <= S_IDLE;
      issued_q <= 1'b0;
      ifr_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      if (done || state_d != state_q || bus_error_in) begin
        issued_q <= 1'b0;
      end else if (cmd_valid_out && cmd_ready_in) begin
        issued_q <= 1'b1;
      end
      if (state_q == S_IDLE && state_d != S_IDLE) begin
        ifr_q <= (state_d == S_NB);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_out <= '{op: OP_NONE, data: 8'h00};
    end else begin
      case (state_d)
        S_NB:    cmd_out <= '{op: OP_NB, data: {7'h00, eff[1] ^ norm_bit_format_sel_q}}; // R3 R10
        S_BYTE:  cmd_out <= '{op: OP_BYTE, data: move ? shadow_q : shift_q};
        S_CRC:   cmd_out <= '{op: OP_CRC, data: 8'h00};
        S_EOD:   cmd_out <= '{op: OP_EOD, data: 8'h00};
        S_ONES:  cmd_out <= '{op: OP_ONES, data: 8'hff};
        default: cmd_out <= '{op: OP_NONE, data: 8'h00};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence last_byte_done_s;
    state_q == S_BYTE && done && !bus_error_in && !arb_lost_in && !eff[2] && !shadow_full_q;
  endsequence

  sequence start_ifr_s;
    state_q == S_IDLE && eff != 3'b000 && eod_rx_in && !fast_q && !bus_error_in;
  endsequence

  fast_break_a: assert property (break_rx_in |=> !fast_q) // R2
    else $error("fast bit survived a break");
  sv_break_a: assert property (break_rx_in |=> sv_rd == SV_INVALID) // R2
    else $error("state vector not invalid after break");
  eod_transmit_data_empty_a: assert property (eod_set && !move |=> !transmit_data_empty_q) // R6
    else $error("empty flag kept after end request");
  prio_enc_a: assert property (req_q[2] |-> eff == 3'b100 and (req_q[1] |-> !eff[0])) // R8
    else $error("response requests not priority encoded");
  nb_first_a: assert property (start_ifr_s |=> cmd_valid_out && cmd_out.op == OP_NB
                               && cmd_out.data[0] == ($past(eff[1]) ^ $past(norm_bit_format_sel_q))) // R10
    else $error("response did not open with the normalization bit");
  crc_next_a: assert property (last_byte_done_s ##0 (eod_q && !(ifr_q && eff[0]))
                               |=> cmd_out.op == OP_CRC) // R4
    else $error("crc did not follow the last byte");
  nocrc_eod_a: assert property (last_byte_done_s ##0 (eod_q && ifr_q && eff[0])
                                |=> cmd_out.op == OP_EOD) // R17
    else $error("no-crc response did not end with end symbol");
  late_req_a: assert property (wr_ctrl && eod_seen_q && !req_q[2] |=> !req_q[2]) // R13
    else $error("single request set after end symbol");
  err_clear_a: assert property (bus_error_in |=> req_q == 3'b000 && state_q == S_IDLE) // R18
    else $error("requests not cleared on bus error");
  single_retry_a: assert property (state_q == S_BYTE && arb_lost_in && ifr_q && eff[2]
                                   && !bus_error_in |=> state_q == S_RETRY) // R15
    else $error("single response loss did not wait to retry");

endmodule

// >>> testbench/jitc_engine_model.sv
// symbol engine stand-in on the far side of the command link
// assumes one command per valid/ready handshake; answers with done or loss
`timescale 1ns/10ps
module jitc_engine_model
  import jitc_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                cmd_valid_in,
  input  wire jitc_pkg::jitc_cmd_t cmd_in,
  input  wire logic [7:0]          delay_in,
  input  wire logic                lose_in,
  input  wire logic                last_bit_in,
  output logic                     cmd_ready_out,
  output logic                     sym_done_out,
  output logic                     arb_lost_out,
  output logic                     arb_last_bit_out
);
  // ----------------------------------------------------------------------
  // symbol timing
  // ----------------------------------------------------------------------
  logic       busy_q;
  logic       byte_q;
  logic [7:0] cnt_q;

  assign cmd_ready_out = !busy_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q           <= 1'b0;
      byte_q           <= 1'b0;
      cnt_q            <= 8'h00;
      sym_done_out     <= 1'b0;
      arb_lost_out     <= 1'b0;
      arb_last_bit_out <= 1'b0;
    end else begin
      sym_done_out     <= 1'b0;
      arb_lost_out     <= 1'b0;
      arb_last_bit_out <= 1'b0;
      if (cmd_valid_in && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= delay_in;
        byte_q <= (cmd_in.op == OP_BYTE);
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        // a byte is lost to another responder only when the bench asks
        if (lose_in && byte_q) begin
          arb_lost_out     <= 1'b1;
          arb_last_bit_out <= last_bit_in;
        end else begin
          sym_done_out <= 1'b1;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// >>> testbench/jitc_transmit_control_tb.sv
// self-checking bench for the transmit control block
// assumes the engine model on the command link and axi4-lite register access
`timescale 1ns/10ps
module jitc_transmit_control_tb;
  import jitc_pkg::*;
  logic             clk_in, rst_n_in, awvalid, wvalid, arvalid, bready, rready;
  logic [3:0]       awaddr, araddr;
  logic [31:0]      wdata, rd;
  logic [5:0]       ev;
  logic [7:0]       delay;
  logic             lose, last;
  logic [1:0]       rsp, bresp, rresp;
  logic             awready, wready, bvalid, arready, rvalid, fast, nbx;
  logic [31:0]      rdata;
  logic             cmd_valid, cmd_ready, sym_done, arb_lost, arb_last;
  jitc_cmd_t        cmd;
  jitc_cmd_t        ops[$];
  int               err_total, tests_run;
  logic [7:0]       cv[6] = '{8'h07, 8'h27, 8'h03, 8'h23, 8'h01, 8'h21};
  logic             nv[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam int    E_WIN = 0, E_CRC = 1, E_EOD = 2, E_EOF = 3, E_BRK = 4, E_ERR = 5;

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  jitc_transmit_control jitc_transmit_control_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .cmd_valid_out(cmd_valid), .cmd_ready_in(cmd_ready),
    .cmd_out(cmd), .sym_done_in(sym_done), .arb_lost_in(arb_lost),
    .arb_last_bit_in(arb_last), .win_byte_done_in(ev[E_WIN]), .crc_first_bit_in(ev[E_CRC]),
    .eod_rx_in(ev[E_EOD]), .eof_rx_in(ev[E_EOF]), .break_rx_in(ev[E_BRK]),
    .bus_error_in(ev[E_ERR]), .fast_receive_enable_out(fast), .norm_bit_expect_out(nbx));

  jitc_engine_model jitc_engine_model_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .delay_in(delay), .lose_in(lose), .last_bit_in(last), .cmd_ready_out(cmd_ready),
    .sym_done_out(sym_done), .arb_lost_out(arb_lost), .arb_last_bit_out(arb_last));

  always @(posedge clk_in) begin
    if (cmd_valid && cmd_ready) begin
      ops.push_back(cmd);
    end
  end

  // ----------------------------------------------------------------------
  // compare, bus and event tasks
  // ----------------------------------------------------------------------
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cmd(input jitc_cmd_t got, input jitc_cmd_t exp);
    logic ok;
    ok = (got.op === exp.op);
    if (exp.op == OP_BYTE) ok = ok && (got.data === exp.data);
    if (exp.op == OP_NB) ok = ok && (got.data[0] === exp.data[0]);
    tests_run++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: command %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_ops(input jitc_cmd_t e[$]);
    check_reg(32'(ops.size()), 32'(e.size()));
    foreach (e[i]) if (i < ops.size()) check_cmd(ops[i], e[i]);
    ops.delete();
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic aw, w, b;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {aw, w, b, n} = '0;
    while (!b && n < 200) begin
      @(posedge clk_in);
      n++;
      if (bvalid) begin
        b = 1'b1;
        bready <= 1'b0;
        check_reg({30'h0, bresp}, {30'h0, er});
      end
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!b) check_reg(32'h0, 32'h1);
  endtask

  task automatic rdr(input logic [3:0] a);
    int n;
    logic ar, r;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    {ar, r, n} = '0;
    while (!r && n < 200) begin
      @(posedge clk_in);
      n++;
      if (rvalid) begin
        r = 1'b1;
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
      if (!ar && arready) begin
        ar = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (!r) check_reg(32'h0, 32'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
  endtask

  task automatic wait_ops(input int k);
    int n;
    n = 0;
    while (ops.size() < k && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (80) @(posedge clk_in);
  endtask

  task automatic ctrl_is(input logic [7:0] v);
    rdr(OFF_CTRL);
    check_reg(rd, {24'h0, v});
  endtask

  task automatic respond(input logic [7:0] c, input logic [7:0] d, input int k);
    wr(OFF_CTRL, c);
    wr(OFF_DATA, d);
    pulse(E_EOD);
    wait_ops(k);
    lose <= 1'b0;
  endtask

  task automatic test_end(input string s);
    pulse(E_EOF);
    $display("test %s done", s);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    {rst_n_in, awvalid, wvalid, arvalid, bready, rready, lose, last} = '0;
    {awaddr, araddr, wdata, ev, err_total, tests_run} = '0;
    delay = 8'd3;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (cv[i]) if (i < 3) begin
      rdr(4'(4 * i));
      check_reg(rd, 32'h0);
    end
    rdr(4'hc);
    check_reg({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(4'hc, 8'h01, RESP_SLVERR);
    foreach (cv[i]) begin
      wr(OFF_CTRL, cv[i]);
      ctrl_is(cv[i]);
      check_reg({31'h0, nbx}, {31'h0, nv[i]});
    end
    wr(OFF_CTRL, 8'h0c);
    rdr(OFF_CTRL);
    check_reg(rd & 32'h4, 32'h0);
    wr(OFF_CTRL, 8'h40);
    check_reg({31'h0, fast}, 32'h1);
    pulse(E_BRK);
    @(posedge clk_in);
    check_reg({31'h0, fast}, 32'h0);
    rdr(OFF_SV);
    check_reg(rd, {24'h0, SV_INVALID});
    ctrl_is(8'h00);
    test_end("registers");
    respond(8'h04, 8'ha5, 2);
    check_ops('{{OP_NB, 8'h00}, {OP_BYTE, 8'ha5}});
    ctrl_is(8'h00);
    test_end("single");
    lose <= 1'b1;
    last <= 1'b1;
    respond(8'h04, 8'h3c, 2);
    pulse(E_WIN);
    wait_ops(3);
    check_ops('{{OP_NB, 8'h00}, {OP_BYTE, 8'h3c}, {OP_BYTE, 8'h3c}});
    ctrl_is(8'h00);
    test_end("single retry");
    lose <= 1'b1;
    respond(8'h01, 8'h66, 3);
    check_ops('{{OP_NB, 8'h00}, {OP_BYTE, 8'h66}, {OP_ONES, 8'h00}});
    ctrl_is(8'h00);
    test_end("multi loss");
    respond(8'h01, 8'h44, 2);
    check_ops('{{OP_NB, 8'h00}, {OP_BYTE, 8'h44}});
    ctrl_is(8'h00);
    test_end("underrun");
    delay <= 8'd60;
    respond(8'h04, 8'h99, 0);
    pulse(E_ERR);
    wait_ops(0);
    ctrl_is(8'h00);
    ops.delete();
    test_end("bus error");
    wr(OFF_CTRL, 8'h01);
    wr(OFF_DATA, 8'h11);
    pulse(E_EOD);
    while (ops.size() < 2) @(posedge clk_in);
    rdr(OFF_SV);
    check_reg(rd, {24'h0, SV_TRANSMIT_DATA_EMPTY});
    wr(OFF_DATA, 8'h22);
    while (ops.size() < 3) @(posedge clk_in);
    rdr(OFF_SV);
    check_reg(rd, {24'h0, SV_TRANSMIT_DATA_EMPTY});
    wr(OFF_CTRL, 8'h09);
    rdr(OFF_SV);
    check_reg(rd, {24'h0, SV_NONE});
    wait_ops(4);
    check_ops('{{OP_NB, 8'h00}, {OP_BYTE, 8'h11}, {OP_BYTE, 8'h22}, {OP_EOD, 8'h00}});
    pulse(E_EOD);
    @(posedge clk_in);
    ctrl_is(8'h00);
    test_end("multi nocrc");
    wr(OFF_CTRL, 8'h02);
    wr(OFF_DATA, 8'h55);
    pulse(E_EOD);
    while (ops.size() < 2) @(posedge clk_in);
    wr(OFF_CTRL, 8'h0a);
    wait_ops(4);
    check_ops('{{OP_NB, 8'h01}, {OP_BYTE, 8'h55}, {OP_CRC, 8'h00}, {OP_EOD, 8'h00}});
    pulse(E_EOD);
    @(posedge clk_in);
    ctrl_is(8'h00);
    test_end("multi crc");
    wr(OFF_DATA, 8'h81);
    while (ops.size() < 1) @(posedge clk_in);
    wr(OFF_DATA, 8'h82);
    wr(OFF_CTRL, 8'h08);
    while (ops.size() < 3) @(posedge clk_in);
    pulse(E_CRC);
    ctrl_is(8'h00);
    wait_ops(4);
    check_ops('{{OP_BYTE, 8'h81}, {OP_BYTE, 8'h82}, {OP_CRC, 8'h00}, {OP_EOD, 8'h00}});
    test_end("main message");
    pulse(E_EOD);
    foreach (cv[i]) if (i > 3) begin
      wr(OFF_CTRL, {6'h0, i[0], ~i[0]} << i[0]);
      ctrl_is(8'h00);
    end
    wait_ops(0);
    check_ops('{});
    test_end("late request");
    finish_test();
  end
endmodule
